/* File: design/sar_adc_consts.svh */
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH
`define CLK_PERIOD_PS 4000
`define CONV_MIN_NS 500
`define CONV_MAX_NS 8800
`define CONV_MIN_CYC ((`CONV_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CONV_MAX_CYC ((`CONV_MAX_NS * 1000) / `CLK_PERIOD_PS)
`define RESULT_BITS 16
`define BITCNT_W 5
`define CONV_CNT_W 12
`define SCLK_HALF_CYC 4
`endif

/* File: design/sar_adc_pkg.sv */
package sar_adc_pkg;
  typedef enum logic [1:0] {MODE_NONE, MODE_CS, MODE_CHAIN} mode_e;
  typedef logic [15:0] sample_t;
endpackage

/* File: design/sar_adc_link_if.sv */
`timescale 1ns/1ps
interface sar_adc_link_if;
  logic convertStartPin;
  logic serialIn;
  logic serialClk;
  logic serialOut;
  logic serialOutEnN;
  logic dataLine;
  assign dataLine = serialOutEnN ? 1'b1 : serialOut;
  modport dev (input convertStartPin, input serialIn, input serialClk, output serialOut, output serialOutEnN);
  modport host (output convertStartPin, output serialIn, output serialClk, input dataLine);
endinterface

/* File: design/sar_adc_device.sv */
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
// Notes on behaviour
// - start edge picks mode from serial input
// - conversion on internal clock, serial clock reads
// - conversion length within min and max
// - after conversion, acquire powered down, result readable
// - result is unsigned straight binary
// - 3-wire start edge: tristate output, sample, convert
// - conversion ignores start and select pins
// - host re-raises start before min conversion
// - 3-wire start falling edge drives MSB
// - next bits on each serial clock fall
// - host captures on either clock edge; sar_adc_host captures on the falling edge only
// - 3-wire: tristate after sixteenth fall or start rise
// - 4-wire: serial input is select, start held
// - 4-wire: host re-raises select before min
// - 4-wire select falling edge drives MSB
// - 4-wire: tristate after sixteenth fall or select rise
// - shared line: next select after previous tristates
// - 4-wire: start and select never both low
module sar_adc_device (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  sar_adc_link_if.dev link,
  input wire logic [`CONV_CNT_W-1:0] convCycles,
  input wire sar_adc_pkg::sample_t analogSample,
  output logic converting,
  output logic poweredDown,
  output logic chainSelected
);
  typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_READ} state_e;

  state_e state_q;
  sar_adc_pkg::mode_e mode_q;
  logic startPrev_q;
  logic selPrev_q;
  logic sclkPrev_q;
  logic fresh_q;
  logic [`CONV_CNT_W-1:0] convCnt_q;
  logic [`CONV_CNT_W-1:0] convLen;
  sar_adc_pkg::sample_t held_q;
  sar_adc_pkg::sample_t shift_q;
  logic [`BITCNT_W-1:0] bitCnt_q;
  logic outEn_q;
  logic outBit_q;
  logic startRise;
  logic startFall;
  logic selRise;
  logic selFall;
  logic sclkFall;
  logic readSelFall;
  logic readDeselect;
  logic readStart;
  logic convDone;

  function automatic logic [`CONV_CNT_W-1:0] clampLen(input logic [`CONV_CNT_W-1:0] req);
    if (req < `CONV_CNT_W'(`CONV_MIN_CYC)) clampLen = `CONV_CNT_W'(`CONV_MIN_CYC);
    else if (req > `CONV_CNT_W'(`CONV_MAX_CYC)) clampLen = `CONV_CNT_W'(`CONV_MAX_CYC);
    else clampLen = req;
  endfunction

  function automatic logic rising(input logic cur, input logic prev);
    rising = cur & ~prev;
  endfunction

  function automatic logic falling(input logic cur, input logic prev);
    falling = ~cur & prev;
  endfunction

  assign convLen = clampLen(convCycles);
  assign startRise = rising(link.convertStartPin, startPrev_q);
  assign startFall = falling(link.convertStartPin, startPrev_q);
  assign selRise = rising(link.serialIn, selPrev_q);
  assign selFall = falling(link.serialIn, selPrev_q);
  assign sclkFall = falling(link.serialClk, sclkPrev_q);
  // 3-wire reads on start pin; 4-wire on serial input while start stays high
  assign readSelFall = startFall | (selFall & link.convertStartPin);
  assign readDeselect = startRise | selRise;
  // read opens only once per finished chip-select conversion
  assign readStart = (state_q == ST_ACQ) && readSelFall && (mode_q == sar_adc_pkg::MODE_CS) && fresh_q;
  assign convDone = (state_q == ST_CONV) && (convCnt_q <= `CONV_CNT_W'(1));

  // previous pin samples for edge detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      startPrev_q <= 1'b0;
    end else if (clkEn) begin
      startPrev_q <= link.convertStartPin;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      selPrev_q <= 1'b0;
    end else if (clkEn) begin
      selPrev_q <= link.serialIn;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclkPrev_q <= 1'b0;
    end else if (clkEn) begin
      sclkPrev_q <= link.serialClk;
    end
  end

  // unread result; a stray start fall after a 4-wire read must not drive the line
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fresh_q <= 1'b0;
    end else if (clkEn) begin
      if (convDone) fresh_q <= 1'b1;
      else if (startRise || readStart) fresh_q <= 1'b0;
    end
  end

  // conversion sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_ACQ;
      mode_q <= sar_adc_pkg::MODE_NONE;
      convCnt_q <= '0;
      held_q <= '0;
    end else if (clkEn) begin
      case (state_q)
        ST_ACQ, ST_READ: begin
          if (startRise) begin
            mode_q <= link.serialIn ? sar_adc_pkg::MODE_CS : sar_adc_pkg::MODE_CHAIN;
            held_q <= analogSample;
            convCnt_q <= convLen;
            state_q <= ST_CONV;
          end else if (state_q == ST_READ && (readDeselect || bitCnt_q == '0)) begin
            state_q <= ST_ACQ;
          end else if (readStart) begin
            state_q <= ST_READ;
          end
        end
        ST_CONV: begin
          // internal cycle count only; pins are not looked at here
          if (convDone) begin
            state_q <= ST_ACQ;
          end else begin
            convCnt_q <= convCnt_q - `CONV_CNT_W'(1);
          end
        end
        default: state_q <= ST_ACQ;
      endcase
    end
  end

  // line enable: off for conversion, deselect or last fall
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      outEn_q <= 1'b0;
    end else if (clkEn) begin
      if (state_q == ST_CONV || startRise) begin
        outEn_q <= 1'b0;
      end else if (readStart) begin
        outEn_q <= 1'b1;
      end else if (state_q == ST_READ) begin
        if (readDeselect) begin
          outEn_q <= 1'b0;
        end else if (sclkFall && bitCnt_q == `BITCNT_W'(1)) begin
          outEn_q <= 1'b0;
        end
      end
    end
  end

  // shift register walks one bit per serial clock fall
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shift_q <= '0;
      bitCnt_q <= '0;
      outBit_q <= 1'b0;
    end else if (clkEn) begin
      if (state_q == ST_CONV || startRise) begin
        bitCnt_q <= '0;
      end else if (readStart) begin
        outBit_q <= held_q[`RESULT_BITS-1];
        shift_q <= {held_q[`RESULT_BITS-2:0], 1'b0};
        bitCnt_q <= `BITCNT_W'(`RESULT_BITS);
      end else if (state_q == ST_READ) begin
        if (readDeselect) begin
          bitCnt_q <= '0;
        end else if (sclkFall && bitCnt_q != '0) begin
          bitCnt_q <= bitCnt_q - `BITCNT_W'(1);
          if (bitCnt_q != `BITCNT_W'(1)) begin
            outBit_q <= shift_q[`RESULT_BITS-1];
            shift_q <= {shift_q[`RESULT_BITS-2:0], 1'b0};
          end
        end
      end
    end
  end

  // pins and status straight from registers
  assign link.serialOut = outBit_q;
  assign link.serialOutEnN = ~outEn_q;
  assign converting = (state_q == ST_CONV);
  assign poweredDown = (state_q != ST_CONV);
  assign chainSelected = (mode_q == sar_adc_pkg::MODE_CHAIN);
endmodule

/* File: design/sar_adc_host.sv */
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module sar_adc_host (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  sar_adc_link_if.host link,
  input wire logic startReq,
  input wire logic fourWire,
  output logic busy,
  output logic resultValid,
  output sar_adc_pkg::sample_t result
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_CONV, H_SELECT, H_CLK, H_DONE} hstate_e;
  hstate_e state_q;
  logic [`CONV_CNT_W-1:0] waitCnt_q;
  logic [`BITCNT_W-1:0] bitCnt_q;
  logic [2:0] halfCnt_q;
  logic start_q, sel_q, sclk_q, valid_q, mode4_q;
  sar_adc_pkg::sample_t result_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= H_IDLE;
      start_q <= 1'b0;
      sel_q <= 1'b1;
      sclk_q <= 1'b0;
      waitCnt_q <= '0;
      bitCnt_q <= '0;
      halfCnt_q <= '0;
      valid_q <= 1'b0;
      mode4_q <= 1'b0;
      result_q <= '0;
    end else if (clkEn) begin
      valid_q <= 1'b0;
      case (state_q)
        H_IDLE: begin
          start_q <= 1'b0;
          sel_q <= 1'b1;
          if (startReq) begin
            mode4_q <= fourWire;
            state_q <= H_START;
          end
        end
        H_START: begin
          start_q <= 1'b1; // select held high at the edge picks chip-select mode
          waitCnt_q <= `CONV_CNT_W'(`CONV_MAX_CYC + 2);
          state_q <= H_CONV;
        end
        H_CONV: begin
          // lines held high until max conversion time has passed
          if (waitCnt_q == '0) state_q <= H_SELECT;
          else waitCnt_q <= waitCnt_q - `CONV_CNT_W'(1);
        end
        H_SELECT: begin
          if (mode4_q) sel_q <= 1'b0; // start stays high, never both low
          else start_q <= 1'b0;
          bitCnt_q <= `BITCNT_W'(`RESULT_BITS);
          halfCnt_q <= '0;
          state_q <= H_CLK;
        end
        H_CLK: begin
          halfCnt_q <= halfCnt_q + 3'(1);
          if (halfCnt_q == 3'(`SCLK_HALF_CYC - 1)) begin
            halfCnt_q <= '0;
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              result_q <= {result_q[`RESULT_BITS-2:0], link.dataLine}; // capture on falling edge
              bitCnt_q <= bitCnt_q - `BITCNT_W'(1);
              if (bitCnt_q == `BITCNT_W'(1)) state_q <= H_DONE;
            end
          end
        end
        H_DONE: begin
          sel_q <= 1'b1; // deselect before any other device selects
          start_q <= 1'b0;
          valid_q <= 1'b1;
          state_q <= H_IDLE;
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  assign link.convertStartPin = start_q;
  assign link.serialIn = sel_q;
  assign link.serialClk = sclk_q;
  assign busy = (state_q != H_IDLE);
  assign resultValid = valid_q;
  assign result = result_q;
endmodule

/* File: tb/sar_adc_link_properties.sv */
`timescale 1ns/1ps
module sar_adc_link_properties (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic convertStartPin,
  input wire logic serialIn,
  input wire logic serialClk,
  input wire logic serialOut,
  input wire logic serialOutEnN
);
  logic [3:0] sclkHist_q;
  logic [4:0] fallCnt_q;
  logic armed_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclkHist_q <= 4'h0;
    end else begin
      sclkHist_q <= {sclkHist_q[2:0], serialClk};
    end
  end
  // falls seen while the line is driven
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fallCnt_q <= 5'h00;
    end else if (serialOutEnN) begin
      fallCnt_q <= 5'h00;
    end else if (sclkHist_q[0] && !serialClk) begin
      fallCnt_q <= fallCnt_q + 5'h01;
    end
  end
  // a started conversion not yet read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed_q <= 1'b0;
    end else if ($rose(convertStartPin)) begin
      armed_q <= 1'b1;
    end else if (!serialOutEnN) begin
      armed_q <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_start; $rose(convertStartPin) && serialIn; endsequence
  sequence s_quiet; serialOutEnN [*8]; endsequence
  sequence s_idle4; (convertStartPin && serialIn) [*4]; endsequence
  a_start_quiet: assert property (s_start |-> ##3 s_quiet)
    else $error("line driven during conversion");
  a_idle_release: assert property (s_idle4 |-> serialOutEnN)
    else $error("line driven while deselected");
  a_deselect_release: assert property (($rose(convertStartPin) || $rose(serialIn)) |-> ##[1:3] serialOutEnN)
    else $error("line not released on deselect");
  a_select_drive: assert property (armed_q && ($fell(convertStartPin) && serialIn || $fell(serialIn) && convertStartPin)
    |-> ##[1:3] !serialOutEnN)
    else $error("line not driven on select");
  a_drive_cause: assert property ($fell(serialOutEnN) |-> !convertStartPin || !serialIn)
    else $error("line driven without select");
  a_sixteen_release: assert property (fallCnt_q == 5'h10 |-> ##[0:3] serialOutEnN)
    else $error("line held after last fall");
  a_fall_limit: assert property (!serialOutEnN |-> fallCnt_q <= 5'h10)
    else $error("line driven past last bit");
  a_bit_stable: assert property (!serialOutEnN && $past(!serialOutEnN) && sclkHist_q == {4{serialClk}}
    |-> $stable(serialOut))
    else $error("data changed without clock fall");
endmodule

/* File: tb/tb_sar_adc_serial_readout.sv */
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module tb_sar_adc_serial_readout;
  logic core_clk, nrst, startReq, fourWire, busy, resultValid, converting, poweredDown, chainSelected;
  logic [`CONV_CNT_W-1:0] convCycles;
  sar_adc_pkg::sample_t analogSample, result;
  int bad_count, check_count, convLen;
  sar_adc_link_if link();
  sar_adc_device i_sar_adc_device (.core_clk(core_clk), .nrst(nrst), .clkEn(1'b1), .link(link),
    .convCycles(convCycles), .analogSample(analogSample), .converting(converting),
    .poweredDown(poweredDown), .chainSelected(chainSelected));
  sar_adc_host i_sar_adc_host (.core_clk(core_clk), .nrst(nrst), .clkEn(1'b1), .link(link),
    .startReq(startReq), .fourWire(fourWire), .busy(busy), .resultValid(resultValid), .result(result));
  sar_adc_link_properties i_props (.core_clk(core_clk), .nrst(nrst), .convertStartPin(link.convertStartPin),
    .serialIn(link.serialIn), .serialClk(link.serialClk), .serialOut(link.serialOut),
    .serialOutEnN(link.serialOutEnN));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (converting === 1'b1) convLen <= convLen + 1;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic run_read(input logic fw, input sar_adc_pkg::sample_t s, input logic [11:0] cc, input int expLen);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin @(posedge core_clk); #1; n++; end
    @(posedge core_clk);
    fourWire <= fw;
    analogSample <= s;
    convCycles <= cc;
    convLen <= 0;
    startReq <= 1'b1;
    @(posedge core_clk);
    startReq <= 1'b0;
    n = 0;
    while (converting !== 1'b1 && n < 20) begin @(posedge core_clk); #1; n++; end
    chk({15'h0, poweredDown}, 16'h0000);
    @(posedge core_clk);
    analogSample <= ~s;
    n = 0;
    while (resultValid !== 1'b1 && n < 5000) begin @(posedge core_clk); #1; n++; end
    chk(result, s);
    chk(16'(convLen), 16'(expLen));
    chk({15'h0, poweredDown}, 16'h0001);
    chk({15'h0, chainSelected}, 16'h0000);
    $display("test done fourWire=%0d sample=%h", fw, s);
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    bad_count++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    startReq = 1'b0;
    fourWire = 1'b0;
    convCycles = 12'h0100;
    analogSample = 16'h0000;
    convLen = 0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    run_read(1'b0, 16'h0000, 12'h0010, `CONV_MIN_CYC);
    run_read(1'b1, 16'hFFFF, 12'h0FFF, `CONV_MAX_CYC);
    run_read(1'b0, 16'hA5C3, 12'h0200, 512);
    run_read(1'b1, 16'h8001, 12'h007D, 125);
    run_read(1'b1, 16'h5A3C, 12'h0898, 2200);
    test_done();
  end
endmodule
